// ### core/pllsf_defines.svh
// Offsets, field positions, reset values and thresholds of the
// synthesizer status block.
// Assumes a 32-bit APB register port with byte addresses.
`ifndef PLLSF_DEFINES_SVH
`define PLLSF_DEFINES_SVH

`define PLLSF_ADDR_W 8
`define PLLSF_ADDR_STATUS 8'h00
`define PLLSF_ADDR_CONTROL 8'h04

`define PLLSF_STS_CLK_MODE 7
`define PLLSF_STS_RATIO_SEL 6
`define PLLSF_STS_REF_SRC 5
`define PLLSF_STS_STICKY 4
`define PLLSF_STS_LIVE_LOCK 3
`define PLLSF_STS_LOSS_CLK 2

`define PLLSF_CTL_MULT_LSB 0
`define PLLSF_CTL_MULT_MSB 2
`define PLLSF_CTL_FAST_WAKE 3
`define PLLSF_CTL_STPMD_LSB 4
`define PLLSF_CTL_STPMD_MSB 5
`define PLLSF_CTL_RESET 32'h0000_0000

// Stop-mode settings at or above this one switch the PLL off
`define PLLSF_STPMD_PLL_OFF 2'h2

// Mode codes read as mode:select:reference
`define PLLSF_MODE_EXT 3'h0
`define PLLSF_MODE_ONE 3'h4
`define PLLSF_MODE_NRM_EXT 3'h6
`define PLLSF_MODE_NRM_XTAL 3'h7

// Frequency error thresholds in hundredths of a percent
`define PLLSF_ERR_W 16
`define PLLSF_LOCK_ACQ 16'h004B
`define PLLSF_LOCK_LOSE 16'h0096

`endif

// ### core/pllsf_lock_detect.sv
// Live lock flag with acquire and lose thresholds.
// Assumes freqErr is an absolute error measured on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "pllsf_defines.svh"

module pllsf_lock_detect #(
  parameter logic [`PLLSF_ERR_W-1:0] ACQ_ERR = `PLLSF_LOCK_ACQ,
  parameter logic [`PLLSF_ERR_W-1:0] LOSE_ERR = `PLLSF_LOCK_LOSE
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic detEnable,
  input wire logic [`PLLSF_ERR_W-1:0] freqErr,
  output logic lockFlag
);
  import pllsf_pkg::*;

  logic lock_q;
  logic lock_d;
  wire logic errInside = (freqErr <= ACQ_ERR);
  wire logic errOutside = (freqErr > LOSE_ERR);

  // The gap between the two thresholds keeps the flag from chattering
  always_comb
  begin
    lock_d = lock_q;
    if (!detEnable)
      lock_d = 1'b0;
    else if (!lock_q && errInside)
      lock_d = 1'b1;
    else if (lock_q && errOutside)
      lock_d = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      lock_q <= 1'b0;
    else if (clkEn)
      lock_q <= lock_d;
  end

  assign lockFlag = lock_q;

endmodule
`default_nettype wire

// ### core/pllsf_pkg.sv
// Types shared by the synthesizer status block.
// Assumes pllsf_defines.svh is on the include path.
`include "pllsf_defines.svh"

package pllsf_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PLLSF_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pllsf_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pllsf_apb_rsp_s;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP_OFF,
    ST_WAKE_WAIT
  } pllsf_state_e;

endpackage

// ### core/pllsf_status.sv
// Synthesizer status register with reset-captured clock mode, live and
// sticky lock flags, and the control bits that steer them.
// Assumes an APB master on sys_clk, strap pins from outside the clock
// domain, and frequency error and loss-of-clock from sys_clk logic.
`timescale 1ns/1ns
`default_nettype none
`include "pllsf_defines.svh"

module pllsf_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire pllsf_pkg::pllsf_apb_req_s apbReq,
  output pllsf_pkg::pllsf_apb_rsp_s apbRsp,
  input wire logic [2:0] clkModeStrap,
  input wire logic stopReq,
  input wire logic [`PLLSF_ERR_W-1:0] freqErr,
  input wire logic lossOfClock,
  output logic pllEnable,
  output logic [2:0] multiplierField,
  output logic fastWakeupBit,
  output logic porLockOk
);
  import pllsf_pkg::*;

  // Map any strap pattern onto one of the four legal modes
  function automatic logic [2:0] decodeMode(input logic [2:0] strap);
    logic [2:0] mode;
    mode = `PLLSF_MODE_NRM_EXT;
    if (!strap[2])
      mode = `PLLSF_MODE_EXT;
    else if (!strap[1])
      mode = `PLLSF_MODE_ONE;
    else if (strap[0])
      mode = `PLLSF_MODE_NRM_XTAL;
    return mode;
  endfunction

  // Address decode for the error answer only; the read path compares the address itself
  function automatic logic isMapped(input logic [`PLLSF_ADDR_W-1:0] a);
    return (a == `PLLSF_ADDR_STATUS) || (a == `PLLSF_ADDR_CONTROL);
  endfunction

  // Strap synchroniser, two flops per pin. The flops have no reset, so
  // they follow the pins while rst is high and the mode can be captured
  // from the second flop before reset is released.
  wire logic [2:0] strapSync;

  generate
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_strap
      logic meta_q;
      logic sync_q;

      always_ff @(posedge sys_clk)
      begin
        if (clkEn)
        begin
          meta_q <= clkModeStrap[gi];
          sync_q <= meta_q;
        end
      end

      assign strapSync[gi] = sync_q;
    end
  endgenerate

  // Reset is synchronous, so the mode is taken on the edges while rst
  // is high; hold rst for at least three edges so the value is settled.
  logic [2:0] clkMode_q;
  logic strapSeen_q;
  wire logic [2:0] strapMode = decodeMode(strapSync);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clkMode_q <= strapMode;
      strapSeen_q <= 1'b0;
    end
    else if (clkEn)
      strapSeen_q <= 1'b1;
  end

  wire logic pll_clock_source_flag = clkMode_q[2];

  // Control register: multiplier, fast wakeup and stop behaviour
  logic [2:0] mult_q;
  logic fastWake_q;
  logic [1:0] stpmd_q;
  wire logic [31:0] ctlReset = `PLLSF_CTL_RESET;

  wire logic setupPhase = apbReq.psel && !apbReq.penable;
  wire logic accessPhase = apbReq.psel && apbReq.penable;
  wire logic addrMapped = isMapped(apbReq.paddr);
  wire logic hitControl = apbReq.paddr == `PLLSF_ADDR_CONTROL;
  wire logic hitStatus = apbReq.paddr == `PLLSF_ADDR_STATUS;
  wire logic ctlWrite = accessPhase && apbReq.pwrite && hitControl;
  wire logic [2:0] wrMult =
    apbReq.pwdata[`PLLSF_CTL_MULT_MSB:`PLLSF_CTL_MULT_LSB];
  wire logic multChange = ctlWrite && (wrMult != mult_q);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mult_q <= ctlReset[`PLLSF_CTL_MULT_MSB:`PLLSF_CTL_MULT_LSB];
      fastWake_q <= ctlReset[`PLLSF_CTL_FAST_WAKE];
      stpmd_q <= ctlReset[`PLLSF_CTL_STPMD_MSB:`PLLSF_CTL_STPMD_LSB];
    end
    else if (clkEn && ctlWrite)
    begin
      mult_q <= wrMult;
      fastWake_q <= apbReq.pwdata[`PLLSF_CTL_FAST_WAKE];
      stpmd_q <= apbReq.pwdata[`PLLSF_CTL_STPMD_MSB:`PLLSF_CTL_STPMD_LSB];
    end
  end

  // Stop sequencing for the sticky flag
  pllsf_state_e state_q;
  pllsf_state_e state_d;
  wire logic stopKillsPll = stpmd_q >= `PLLSF_STPMD_PLL_OFF;
  wire logic pllOff = (state_q == ST_STOP_OFF);
  wire logic lockNow;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (stopReq && stopKillsPll && pll_clock_source_flag)
          state_d = ST_STOP_OFF;
      ST_STOP_OFF:
        if (!stopReq)
          state_d = ST_WAKE_WAIT;
      ST_WAKE_WAIT:
        if (lockNow)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= ST_RUN;
    else if (clkEn)
      state_q <= state_d;
  end

  // Live lock detector; idle while the PLL is off or bypassed
  assign pllEnable = pll_clock_source_flag && !pllOff;

  pllsf_lock_detect u_lock (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .detEnable(pllEnable),
    .freqErr(freqErr),
    .lockFlag(lockNow)
  );

  // Sticky lock: armed by reset or a multiplier change, set by lock,
  // cleared by an unintended lock loss.
  logic sticky_q;
  logic sticky_d;
  logic armed_q;
  logic armed_d;
  logic lockPrev_q;
  wire logic lockLost = lockPrev_q && !lockNow;
  wire logic inRun = (state_q == ST_RUN);

  always_comb
  begin
    sticky_d = sticky_q;
    armed_d = armed_q;
    if (!pll_clock_source_flag)
    begin
      sticky_d = 1'b1;
      armed_d = 1'b0;
    end
    else if (inRun)
    begin
      if (multChange)
        armed_d = 1'b1;
      if (lockLost)
      begin
        sticky_d = 1'b0;
        armed_d = 1'b0;
      end
      else if (armed_q && lockNow)
      begin
        // A fresh change in the same cycle keeps the arming for later
        sticky_d = 1'b1;
        armed_d = multChange;
      end
    end
    // Outside run the flag is frozen at its pre-stop value
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // External clock mode must read set at the very first read
      sticky_q <= !strapMode[2];
      armed_q <= 1'b1;
      lockPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      sticky_q <= sticky_d;
      armed_q <= armed_d;
      lockPrev_q <= lockNow;
    end
  end

  // Fast wakeup hides the saved flag until the PLL is locked again
  wire logic stickyShown = (state_q == ST_WAKE_WAIT) && fastWake_q ?
    1'b0 : sticky_q;

  // Status fields, high bit first; loss of clock means nothing without
  // the PLL, so it is masked in external clock mode.
  wire logic [2:0] stsMode = clkMode_q;
  wire logic stsSticky = stickyShown;
  wire logic stsLive = lockNow;
  wire logic stsLoss = lossOfClock && pll_clock_source_flag;
  wire logic [1:0] stsRsvd = 2'h0;

  wire logic [7:0] statusByte = {
    stsMode,
    stsSticky,
    stsLive,
    stsLoss,
    stsRsvd
  };

  wire logic [31:0] controlWord = {
    26'h000_0000,
    stpmd_q,
    fastWake_q,
    mult_q
  };

  wire logic [31:0] readMux =
    hitStatus ? {24'h00_0000, statusByte} :
    hitControl ? controlWord : 32'h0000_0000;

  // Read data is snapped in the setup phase, so a read that meets a
  // lock change in its access cycle returns the state of the cycle
  // before; this saves a combinational path from the detector to prdata.
  logic [31:0] prdata_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (clkEn && setupPhase && !apbReq.pwrite)
      prdata_q <= readMux;
  end

  // Zero wait states; writes to status are dropped without error
  assign apbRsp.pready = 1'b1;
  assign apbRsp.prdata = prdata_q;
  assign apbRsp.pslverr = accessPhase && !addrMapped;

  // Registered lock for the power-on reset release, so that it holds
  // no combinational path back to the detector
  logic porLock_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      porLock_q <= 1'b0;
    else if (clkEn)
      porLock_q <= lockNow && strapSeen_q;
  end

  assign porLockOk = porLock_q;
  assign multiplierField = mult_q;
  assign fastWakeupBit = fastWake_q;

endmodule
`default_nettype wire

// ### tb/pllsf_pll_model.sv
// PLL seen by the status block: frequency error of the loop.
// Assumes pllEnable from the block; error follows it one clock late.
`timescale 1ns/1ns
`default_nettype none
module pllsf_pll_model (
  input wire logic sys_clk,
  input wire logic pllEnable,
  input wire logic [15:0] targetErr,
  output logic [15:0] freqErr
);
  logic [14:0] junk;
  initial junk = 15'h0000;
  initial freqErr = 16'hFFFF;
  // A stopped loop has no valid error: large and moving
  always @(posedge sys_clk)
  begin
    junk <= junk + 15'h0001;
    freqErr <= pllEnable ? targetErr : {1'h1, junk};
  end
endmodule
`default_nettype wire

// ### tb/pllsf_props.sv
// Port checker for the synthesizer status block.
// Assumes clkEn is high around every bus transfer.
`timescale 1ns/1ns
`default_nettype none
module pllsf_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire pllsf_pkg::pllsf_apb_req_s apbReq,
  input wire pllsf_pkg::pllsf_apb_rsp_s apbRsp,
  input wire logic [15:0] freqErr,
  input wire logic pllEnable,
  input wire logic [2:0] multiplierField,
  input wire logic porLockOk
);
  import pllsf_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire accPh = apbReq.psel && apbReq.penable && clkEn;
  wire stsSet = apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
    clkEn && apbReq.paddr == 8'h00;
  wire mapHit = apbReq.paddr == 8'h00 || apbReq.paddr == 8'h04;
  AST_UNMAPPED: assert property (accPh && !mapHit |-> apbRsp.pslverr)
    else $error("unmapped access without error");
  AST_RO_WRITE: assert property (
    accPh && apbReq.pwrite && apbReq.paddr == 8'h00
    |=> $stable(multiplierField)) else $error("status write took effect");
  AST_RSVD: assert property (stsSet |=> apbRsp.prdata[31:8] == '0 &&
    apbRsp.prdata[1:0] == 2'h0) else $error("reserved bits set");
  AST_MODE: assert property (stsSet |=> apbRsp.prdata[7:5] inside
    {3'h0, 3'h4, 3'h6, 3'h7}) else $error("illegal mode code");
  AST_EXT: assert property (stsSet |=> apbRsp.prdata[7] ||
    apbRsp.prdata[4:2] == 3'h4) else $error("external mode lock bits");
  AST_MFD_WR: assert property (
    accPh && apbReq.pwrite && apbReq.paddr == 8'h04
    |=> multiplierField == $past(apbReq.pwdata[2:0]))
    else $error("multiplier not written");
  AST_ACQ: assert property (
    clkEn && pllEnable && freqErr <= 16'h004B ##1 clkEn && pllEnable
    |=> porLockOk) else $error("lock not acquired");
  AST_LOSE: assert property (
    clkEn && freqErr > 16'h0096 ##1 clkEn |=> !porLockOk)
    else $error("lock not lost");
endmodule
bind pllsf_status pllsf_props u_props (.sys_clk(sys_clk), .rst(rst),
  .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp), .freqErr(freqErr),
  .pllEnable(pllEnable), .multiplierField(multiplierField),
  .porLockOk(porLockOk));
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the synthesizer status block.
// Assumes the design, the checker and the PLL model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pllsf_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  pllsf_apb_req_s req = '0;
  pllsf_apb_rsp_s rsp;
  logic [2:0] strap = 3'h0;
  logic stopReq = 0;
  logic loss = 0;
  logic [15:0] target = 16'h00C8;
  logic [15:0] freqErr;
  logic pllEn, fwk, porOk;
  logic [2:0] multOut, m, s;
  logic [31:0] rd;
  logic en = 1;
  logic err;
  logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h5};
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int lfsr = 31;
  int live, sticky, armed, saved, multModel;
  pllsf_status dut (.sys_clk(sys_clk), .rst(rst), .clkEn(en),
    .apbReq(req), .apbRsp(rsp), .clkModeStrap(strap), .stopReq(stopReq),
    .freqErr(freqErr), .lossOfClock(loss), .pllEnable(pllEn),
    .multiplierField(multOut), .fastWakeupBit(fwk), .porLockOk(porOk));
  pllsf_pll_model pll (.sys_clk(sys_clk), .pllEnable(pllEn),
    .targetErr(target), .freqErr(freqErr));
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic int nextRnd(input int v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'h1;
    do
      @(posedge sys_clk);
    while (rsp.pready !== 1'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task automatic chkSts;
    apb(1'h0, 8'h00, '0);
    check(rd, {24'h00_0000, m, sticky[0], live[0], loss & m[2], 2'h0});
    check(porOk, live[0]);
  endtask
  // Latency: one clock in the model plus detector and sticky edges
  task automatic setErr(input int e);
    @(posedge sys_clk);
    target <= e[15:0];
    repeat (4) @(posedge sys_clk);
    if (e <= 75 && m[2])
      live = 1;
    if (e > 150 && live == 1)
    begin
      live = 0;
      sticky = 0;
      armed = 0;
    end
    if (live == 1 && armed == 1)
      sticky = 1;
    chkSts;
  endtask
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      s = codes[i];
      m = s[2] ? (s[1] ? s : 3'h4) : 3'h0;
      lfsr = nextRnd(lfsr);
      @(posedge sys_clk);
      rst <= 1'h1;
      strap <= s;
      loss <= lfsr[0];
      target <= 16'h00C8;
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      live = 0;
      armed = 1;
      sticky = (m == 3'h0);
      multModel = 0;
      chkSts;
      check(multOut, 3'h0);
      check(fwk, 1'h0);
      // A frozen block must not take up a lock that arrives meanwhile
      @(posedge sys_clk);
      en <= 1'h0;
      target <= 16'h000A;
      repeat (4) @(posedge sys_clk);
      check(porOk, 1'h0);
      en <= 1'h1;
      setErr(10);
      setErr(76 + lfsr % 75);
      setErr(200);
      setErr(10);
      apb(1'h1, 8'h00, 32'hFFFF_FFFF);
      check(err, 1'h0);
      chkSts;
      apb(1'h0, 8'h08, '0);
      check(rd, '0);
      check(err, 1'h1);
      lfsr = nextRnd(lfsr);
      if (lfsr[2:0] != multModel[2:0])
        armed = 1;
      multModel = lfsr[2:0];
      apb(1'h1, 8'h04, {29'h0, lfsr[2:0]});
      @(negedge sys_clk);
      check(multOut, multModel[2:0]);
      setErr(10);
      if (m[2])
      begin
        apb(1'h1, 8'h04, {26'h0, 2'h2, 1'h1, lfsr[2:0]});
        saved = sticky;
        @(posedge sys_clk);
        stopReq <= 1'h1;
        repeat (4) @(posedge sys_clk);
        check(fwk, 1'h1);
        target <= 16'h00C8;
        live = 0;
        chkSts;
        check(pllEn, 1'h0);
        @(posedge sys_clk);
        stopReq <= 1'h0;
        repeat (4) @(posedge sys_clk);
        sticky = 0;
        chkSts;
        sticky = saved;
        setErr(10);
      end
      check(pllEn, m[2]);
      $display("test mode %h done", m);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
